// File: logic/fsp_status_one.sv
// Purpose: Volatile first status register with its protect and busy logic
// Assumes: Serial mode 0, link pins sampled on clk, engine on clk
// Notes:   Program, erase and non-volatile register writes run in an outside engine
`timescale 1ns/10ps
`include "fsp_regs.svh"

module fsp_status_one (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Serial link pins
	input  wire logic                 sck,
	input  wire logic                 csN,
	input  wire logic                 si,
	input  wire logic                 wpN,
	output logic                      so,
	output logic                      soEnN,
	// Non-volatile copy and configuration
	input  wire logic [7:0]           statusOneNonvolatile,
	input  wire logic                 nvUpdate,
	input  wire logic                 quadPeripheralMode,
	input  wire logic                 quadIoMode,
	// Internal operation engine
	input  wire logic                 targetProtected,
	input  wire logic                 opDone,
	input  wire logic                 opFail,
	output logic                      opStart,
	output fsp_pkg::fsp_opkind_e      opKind,
	output logic [23:0]               opAddr,
	output logic [7:0]                opData,
	output logic                      suspendReq,
	output logic                      swResetPulse,
	// Status view
	output fsp_pkg::fsp_status_s      statusOneVolatile,
	output logic                      eraseError,
	output logic                      programError,
	output logic                      registerLock
);

	logic [1:0]          rstPipe;
	logic                rstSyncN;
	fsp_pkg::fsp_state_s state_ff;
	fsp_pkg::fsp_state_s nxt_state;
	logic                sckRise;
	logic                sckFall;
	logic                csRise;
	logic                csLow;
	logic                wpInternal;
	logic                locked;
	logic [7:0]          inByte;
	logic [23:0]         fullAddr;

	// Commands still taken while busy
	function automatic logic busyAllowed(input logic [7:0] op);
		busyAllowed = (op == `FSP_OP_READ_STATUS_ONE) || (op == `FSP_OP_READ_STATUS_TWO) ||
			(op == `FSP_OP_READ_ANY_REG) || (op == `FSP_OP_SUSPEND) ||
			(op == `FSP_OP_CLEAR_STATUS) || (op == `FSP_OP_RESET_ENABLE) ||
			(op == `FSP_OP_RESET);
	endfunction : busyAllowed

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSyncN = rstPipe[1];

	// Edges and protection level from synchronised pins
	assign sckRise    = state_ff.sck[1] & ~state_ff.sck[2];
	assign sckFall    = ~state_ff.sck[1] & state_ff.sck[2];
	assign csRise     = state_ff.cs[1] & ~state_ff.cs[2];
	assign csLow      = ~state_ff.cs[1];
	assign wpInternal = state_ff.wp[1] | quadPeripheralMode | quadIoMode;
	assign locked     = state_ff.sr.registerProtectLock & ~wpInternal;
	assign inByte     = {state_ff.shIn[6:0], state_ff.si[1]};
	assign fullAddr   = {state_ff.addr[15:0], inByte};

	// Next-state logic
	always_comb begin
		nxt_state            = state_ff;
		nxt_state.sck        = {state_ff.sck[1:0], sck};
		nxt_state.cs         = {state_ff.cs[1:0], csN};
		nxt_state.si         = {state_ff.si[0], si};
		nxt_state.wp         = {state_ff.wp[0], wpN};
		nxt_state.opStart    = 1'b0;
		nxt_state.suspendReq = 1'b0;
		nxt_state.swReset    = 1'b0;
		nxt_state.regLock    = locked;

		// Defaults from the non-volatile copy after any reset
		if (state_ff.boot) begin
			nxt_state.sr   = statusOneNonvolatile;
			nxt_state.boot = 1'b0;
		end

		// Lock and origin track their non-volatile bits
		if (nvUpdate) begin
			nxt_state.sr.registerProtectLock = statusOneNonvolatile[`FSP_BIT_LOCK];
			nxt_state.sr.protectOriginBottom = statusOneNonvolatile[`FSP_BIT_ORIGIN];
		end

		// Frame end: idle the link side
		if (!csLow) begin
			nxt_state.phase   = fsp_pkg::PH_IDLE;
			nxt_state.bitCnt  = 3'h0;
			nxt_state.outCnt  = 3'h0;
			nxt_state.byteCnt = 3'h0;
			nxt_state.soEnN   = 1'b1;
		end

		// Commands that act when chip select rises
		if (csRise && state_ff.phase == fsp_pkg::PH_CMD) begin
			nxt_state.rstArmed = 1'b0;
			case (state_ff.opcode)
				`FSP_OP_WRITE_ENABLE: begin
					nxt_state.sr.writeEnableLatch = 1'b1;
				end
				`FSP_OP_WRITE_DISABLE: begin
					nxt_state.sr.writeEnableLatch = 1'b0;
					nxt_state.volEn               = 1'b0;
				end
				`FSP_OP_VOLATILE_WRITE_ENABLE_CMD: begin
					nxt_state.volEn = 1'b1;
				end
				`FSP_OP_CLEAR_STATUS: begin
					if (state_ff.eraseErr || state_ff.progErr) begin
						nxt_state.sr.busyFlag = 1'b0;
					end
					nxt_state.eraseErr            = 1'b0;
					nxt_state.progErr             = 1'b0;
					nxt_state.sr.writeEnableLatch = 1'b0;
				end
				`FSP_OP_RESET_ENABLE: begin
					nxt_state.rstArmed = 1'b1;
				end
				`FSP_OP_RESET: begin
					if (state_ff.rstArmed) begin
						nxt_state.boot     = 1'b1;
						nxt_state.swReset  = 1'b1;
						nxt_state.eraseErr = 1'b0;
						nxt_state.progErr  = 1'b0;
						nxt_state.volEn    = 1'b0;
						nxt_state.kind     = fsp_pkg::OPK_NONE;
					end
				end
				`FSP_OP_SUSPEND: begin
					if (state_ff.sr.busyFlag && !state_ff.eraseErr && !state_ff.progErr &&
						(state_ff.kind == fsp_pkg::OPK_PROGRAM || state_ff.kind == fsp_pkg::OPK_ERASE)) begin
						nxt_state.suspendReq = 1'b1;
					end
				end
				`FSP_OP_PROGRAM, `FSP_OP_ERASE: begin
					if (state_ff.byteCnt >= `FSP_ADDR_END_BYTE && state_ff.sr.writeEnableLatch &&
						!state_ff.sr.busyFlag) begin
						nxt_state.sr.busyFlag = 1'b1;
						nxt_state.kind = (state_ff.opcode == `FSP_OP_ERASE) ?
							fsp_pkg::OPK_ERASE : fsp_pkg::OPK_PROGRAM;
						if (targetProtected) begin
							if (state_ff.opcode == `FSP_OP_ERASE) begin
								nxt_state.eraseErr = 1'b1;
							end else begin
								nxt_state.progErr = 1'b1;
							end
						end else begin
							nxt_state.opStart = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Shift in on rising clock edges
		if (csLow && sckRise) begin
			nxt_state.shIn   = inByte;
			nxt_state.bitCnt = state_ff.bitCnt + 3'h1;
			if (state_ff.bitCnt == `FSP_LAST_BIT) begin
				if (state_ff.byteCnt != `FSP_LAST_BIT) begin
					nxt_state.byteCnt = state_ff.byteCnt + 3'h1;
				end
				if (state_ff.byteCnt == 3'h0) begin
					nxt_state.opcode = inByte;
					if (state_ff.sr.busyFlag && !busyAllowed(inByte)) begin
						nxt_state.phase = fsp_pkg::PH_DROP;
					end else if (inByte == `FSP_OP_READ_STATUS_ONE) begin
						nxt_state.phase  = fsp_pkg::PH_READ;
						nxt_state.rdLive = 1'b1;
						nxt_state.shOut  = state_ff.sr;
					end else begin
						nxt_state.phase = fsp_pkg::PH_CMD;
					end
				end else if (state_ff.phase == fsp_pkg::PH_CMD) begin
					if (state_ff.byteCnt <= `FSP_ADDR_BYTES) begin
						nxt_state.addr = fullAddr;
					end
					// Register write: volatile path sets upper six bits only, never latch or busy
					if (state_ff.opcode == `FSP_OP_WRITE_REGISTERS && state_ff.byteCnt == 3'h1 && !locked) begin
						if (state_ff.volEn) begin
							nxt_state.sr[7:2] = inByte[7:2];
							nxt_state.volEn   = 1'b0;
						end else if (state_ff.sr.writeEnableLatch) begin
							nxt_state.opData      = inByte;
							nxt_state.kind        = fsp_pkg::OPK_REGISTER;
							nxt_state.opStart     = 1'b1;
							nxt_state.sr.busyFlag = 1'b1;
						end
					end
					// Any-register write into the volatile byte
					if (state_ff.opcode == `FSP_OP_WRITE_ANY_REG && state_ff.byteCnt == `FSP_ADDR_END_BYTE &&
						state_ff.addr == `FSP_ADDR_STATUS_ONE_V && !locked &&
						(state_ff.volEn || state_ff.sr.writeEnableLatch)) begin
						nxt_state.sr[7:2]             = inByte[7:2];
						nxt_state.sr.writeEnableLatch = 1'b0;
						nxt_state.volEn               = 1'b0;
					end
					// Any-register read after the address
					if (state_ff.opcode == `FSP_OP_READ_ANY_REG && state_ff.byteCnt == `FSP_ADDR_BYTES) begin
						nxt_state.phase  = fsp_pkg::PH_READ;
						nxt_state.rdLive = (fullAddr == `FSP_ADDR_STATUS_ONE_V);
						nxt_state.shOut  = (fullAddr == `FSP_ADDR_STATUS_ONE_V) ? state_ff.sr : 8'h00;
					end
				end
			end
		end

		// Shift out on falling edges, reloading each byte
		if (csLow && sckFall && state_ff.phase == fsp_pkg::PH_READ) begin
			nxt_state.so     = state_ff.shOut[7];
			nxt_state.soEnN  = 1'b0;
			nxt_state.outCnt = state_ff.outCnt + 3'h1;
			if (state_ff.outCnt == `FSP_LAST_BIT) begin
				nxt_state.shOut = state_ff.rdLive ? state_ff.sr : 8'h00;
			end else begin
				nxt_state.shOut = {state_ff.shOut[6:0], 1'b0};
			end
		end

		// Engine completion after the link, so errors win over clear
		if (opDone && state_ff.sr.busyFlag) begin
			if (opFail) begin
				if (state_ff.kind == fsp_pkg::OPK_ERASE) begin
					nxt_state.eraseErr = 1'b1;
				end else begin
					nxt_state.progErr = 1'b1;
				end
			end else begin
				nxt_state.sr.busyFlag         = 1'b0;
				nxt_state.sr.writeEnableLatch = 1'b0;
				nxt_state.kind                = fsp_pkg::OPK_NONE;
			end
		end

		// Any error keeps the device busy
		if (nxt_state.eraseErr || nxt_state.progErr) begin
			nxt_state.sr.busyFlag = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_ff       <= '0;
			state_ff.cs    <= 3'h7;
			state_ff.soEnN <= 1'b1;
			state_ff.boot  <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from the state register
	assign so                = state_ff.so;
	assign soEnN             = state_ff.soEnN;
	assign opStart           = state_ff.opStart;
	assign opKind            = state_ff.kind;
	assign opAddr            = state_ff.addr;
	assign opData            = state_ff.opData;
	assign suspendReq        = state_ff.suspendReq;
	assign swResetPulse      = state_ff.swReset;
	assign statusOneVolatile = state_ff.sr;
	assign eraseError        = state_ff.eraseErr;
	assign programError      = state_ff.progErr;
	assign registerLock      = state_ff.regLock;

endmodule : fsp_status_one

// File: pkg/fsp_pkg.sv
// Purpose: Types of the first status register block
// Assumes: Constants come from fsp_regs.svh
// Notes:   Status byte fields are packed MSB first
package fsp_pkg;

	// Volatile status byte layout
	typedef struct packed {
		logic       registerProtectLock;
		logic       protectGranularitySelect;
		logic       protectOriginBottom;
		logic [2:0] rangeProtect;
		logic       writeEnableLatch;
		logic       busyFlag;
	} fsp_status_s;

	// Serial frame phases
	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_READ, PH_DROP} fsp_phase_e;

	// Kind of the internal operation in flight
	typedef enum logic [1:0] {OPK_NONE, OPK_PROGRAM, OPK_ERASE, OPK_REGISTER} fsp_opkind_e;

	// Whole state of the block
	typedef struct packed {
		logic [2:0]  sck;
		logic [2:0]  cs;
		logic [1:0]  si;
		logic [1:0]  wp;
		fsp_phase_e  phase;
		logic [2:0]  bitCnt;
		logic [2:0]  outCnt;
		logic [2:0]  byteCnt;
		logic [7:0]  shIn;
		logic [7:0]  shOut;
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  opData;
		logic        rdLive;
		logic        so;
		logic        soEnN;
		fsp_status_s sr;
		logic        volEn;
		logic        rstArmed;
		logic        boot;
		logic        eraseErr;
		logic        progErr;
		fsp_opkind_e kind;
		logic        opStart;
		logic        suspendReq;
		logic        swReset;
		logic        regLock;
	} fsp_state_s;

endpackage : fsp_pkg

// File: pkg/fsp_regs.svh
// Purpose: Constants of the first status register block
// Assumes: Single-byte opcodes, 24-bit any-register addresses
// Notes:   Included by the logic file
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Command opcodes
`define FSP_OP_READ_STATUS_ONE   8'h05
`define FSP_OP_READ_STATUS_TWO   8'h07
`define FSP_OP_VOLATILE_WRITE_ENABLE_CMD     8'h50
`define FSP_OP_CLEAR_STATUS      8'h30
`define FSP_OP_WRITE_REGISTERS   8'h01
`define FSP_OP_READ_ANY_REG      8'h65
`define FSP_OP_WRITE_ANY_REG     8'h71
`define FSP_OP_WRITE_ENABLE      8'h06
`define FSP_OP_WRITE_DISABLE     8'h04
`define FSP_OP_RESET_ENABLE      8'h66
`define FSP_OP_RESET             8'h99
`define FSP_OP_SUSPEND           8'h75
`define FSP_OP_PROGRAM           8'h02
`define FSP_OP_ERASE             8'h20

// Any-register address of the volatile status byte
`define FSP_ADDR_STATUS_ONE_V    24'h800000

// Field positions in the status byte
`define FSP_BIT_LOCK             7
`define FSP_BIT_ORIGIN           5

// Byte counts of command frames
`define FSP_ADDR_BYTES           3'h3
`define FSP_ADDR_END_BYTE        3'h4
`define FSP_LAST_BIT             3'h7

`endif

// File: verif/fsp_host_model.sv
// Purpose: Host controller model driving the serial link
// Assumes: Mode 0, link clock of eight clk cycles
// Notes:   Link clock idles low, data in toggles when unused
`timescale 1ns/10ps
module fsp_host_model (
	// Clock
	input  wire logic clk,
	// Serial link
	input  wire logic so,
	output logic      sck,
	output logic      csN,
	output logic      si
);
	initial sck = 1'b0;
	initial csN = 1'b1;
	initial si = 1'b0;
	// Data in toggles while deselected
	always @(posedge clk) if (csN) si <= ~si;
	// One frame: n bytes out MSB first, then r bytes read back
	task automatic xfer(input logic [39:0] t, input int n, input int r, output logic [15:0] rx);
		rx = 16'h0;
		@(posedge clk) csN <= 1'b0;
		for (int i = 0; i < 8 * (n + r); i++) begin
			@(posedge clk) si <= (i < 8 * n) ? t[39 - i] : ~si;
			repeat (3) @(posedge clk);
			sck <= 1'b1;
			#1 if (i >= 8 * n) rx = {rx[14:0], so};
			repeat (4) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		csN <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : xfer
endmodule : fsp_host_model

// File: verif/fsp_status_one_chk.sv
// Purpose: Concurrent checks of the first status register block
// Assumes: Top ports only, one clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module fsp_status_one_chk (
	// Clock, reset and pins
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 wpN,
	input  wire logic [7:0]           statusOneNonvolatile,
	input  wire logic                 nvUpdate,
	// Engine side
	input  wire logic                 opDone,
	input  wire logic                 opFail,
	input  wire logic                 opStart,
	input  wire fsp_pkg::fsp_opkind_e opKind,
	input  wire logic                 suspendReq,
	input  wire logic                 swResetPulse,
	// Status view
	input  wire fsp_pkg::fsp_status_s statusOneVolatile,
	input  wire logic                 eraseError,
	input  wire logic                 programError,
	input  wire logic                 registerLock
);
	logic bsy;
	logic write_enable_latch;
	// Short names for the status flags
	assign bsy = statusOneVolatile.busyFlag;
	assign write_enable_latch = statusOneVolatile.writeEnableLatch;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Engine completions while busy
	sequence s_ok_end;
		opDone && !opFail && bsy && !eraseError && !programError;
	endsequence
	sequence s_bad_end;
		opDone && opFail && bsy;
	endsequence
	a_start_with_latch: assert property (opStart |-> write_enable_latch ##[0:1] bsy)
		else $error("op started without latch or busy");
	a_err_holds_busy: assert property ((eraseError || programError) |-> bsy)
		else $error("error flag without busy");
	a_ok_end_clears: assert property (s_ok_end |=> !bsy && !write_enable_latch)
		else $error("good completion left busy or latch");
	a_bad_end_holds: assert property (s_bad_end |=> bsy && (eraseError || programError))
		else $error("failed completion not held");
	a_suspend_array_only: assert property (suspendReq |-> bsy && opKind inside {fsp_pkg::OPK_PROGRAM, fsp_pkg::OPK_ERASE})
		else $error("suspend outside array op");
	a_pin_high_unlocks: assert property (wpN [*6] |-> !registerLock)
		else $error("lock with pin high");
	a_locked_freeze: assert property (registerLock && !nvUpdate |=> $stable(statusOneVolatile[7:2]))
		else $error("locked status changed");
	a_reset_reload: assert property (swResetPulse |-> ##[0:2] statusOneVolatile == statusOneNonvolatile)
		else $error("soft reset did not reload");
endmodule : fsp_status_one_chk

// File: verif/fsp_status_one_tb_top.sv
// Purpose: Self-checking bench of the first status register block
// Assumes: Host model on the link, bench acts as the op engine
// Notes:   ex holds the expected status byte
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module fsp_status_one_tb_top;
	// Stimulus and bookkeeping
	logic                 clk = 1'b0, rst_n = 1'b0, wpN = 1'b1, nvUpdate = 1'b0, qpm = 1'b0, quad_io_mode = 1'b0;
	logic                 tprot = 1'b0, opDone = 1'b0, opFail = 1'b0;
	logic [7:0]           nv, ex, b, ld, opData;
	logic [15:0]          rx;
	logic [23:0]          a, la, opAddr;
	logic [31:0]          seed = 32'd74999;
	int                   fail_count = 0, total_checks = 0, nst = 0, nsus = 0, nrst = 0;
	logic                 sck, csN, si, so, soEnN, opStart, suspendReq, swResetPulse, eraseError, programError, regLock;
	fsp_pkg::fsp_opkind_e lk, opKind;
	fsp_pkg::fsp_status_s sr;
	fsp_host_model u_host (.clk(clk), .so(so), .sck(sck), .csN(csN), .si(si));
	fsp_status_one u_dut (.clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .wpN(wpN), .so(so), .soEnN(soEnN),
		.statusOneNonvolatile(nv), .nvUpdate(nvUpdate), .quadPeripheralMode(qpm), .quadIoMode(quad_io_mode),
		.targetProtected(tprot), .opDone(opDone), .opFail(opFail), .opStart(opStart), .opKind(opKind),
		.opAddr(opAddr), .opData(opData), .suspendReq(suspendReq), .swResetPulse(swResetPulse),
		.statusOneVolatile(sr), .eraseError(eraseError), .programError(programError), .registerLock(regLock));
	always #50 clk = ~clk;
	// Count engine requests and latch their fields
	always @(posedge clk) begin
		nsus <= nsus + int'(suspendReq);
		nrst <= nrst + int'(swResetPulse);
		if (opStart) begin
			nst <= nst + 1;
			lk <= opKind;
			la <= opAddr;
			ld <= opData;
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] wv(input logic [7:0] d, input logic [7:0] o);
		return {d[7:2], o[1:0]};
	endfunction : wv
	task automatic cmd(input logic [39:0] t, input int n, input int r);
		u_host.xfer(t, n, r, rx);
	endtask : cmd
	task automatic c1(input logic [7:0] o);
		cmd({o, 32'h0}, 1, 0);
	endtask : c1
	task automatic st(input logic [7:0] e);
		cmd({8'h05, 32'h0}, 1, 1);
		`CHK(rx[7:0], e)
		`CHK(soEnN, 1'b1)
	endtask : st
	task automatic vw(input logic [7:0] d);
		c1(8'h50);
		cmd({8'h01, d, 24'h0}, 2, 0);
	endtask : vw
	task automatic eng(input logic f);
		opDone <= 1'b1;
		opFail <= f;
		@(posedge clk) opDone <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : eng
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Watchdog against a hung run
	initial begin
		#5ms;
		fail_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		nv = 8'(xs()) & 8'hfc;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		ex = nv;
		st(ex);
		`CHK(sr, ex)
		c1(8'h06);
		st(ex | 8'h02);
		c1(8'h04);
		st(ex);
		$display("end latch");
		for (int i = 0; i < 4; i++) begin
			b = 8'(xs());
			vw(b);
			ex = wv(b, ex);
			st(ex);
		end
		cmd({8'h65, 24'h800000, 8'h0}, 4, 2);
		`CHK(rx, {ex, ex})
		cmd({8'h65, 24'h000010, 8'h0}, 4, 1);
		`CHK(rx[7:0], 8'h00)
		c1(8'h06);
		b = 8'(xs()) & 8'h7c;
		cmd({8'h71, 24'h800000, b}, 5, 0);
		ex = wv(b, 8'h00);
		st(ex);
		$display("end volatile");
		c1(8'h06);
		b = 8'(xs());
		cmd({8'h01, b, 24'h0}, 2, 0);
		`CHK(lk, fsp_pkg::OPK_REGISTER)
		`CHK(ld, b)
		c1(8'h04);
		c1(8'h75);
		st(ex | 8'h03);
		`CHK(nsus, 0)
		eng(1'b0);
		st(ex);
		cmd({8'h02, 24'h001000, 8'h0}, 4, 0);
		st(ex);
		`CHK(nst, 1)
		c1(8'h06);
		tprot <= 1'b1;
		cmd({8'h02, 24'h002000, 8'h0}, 4, 0);
		`CHK(programError, 1'b1)
		st(ex | 8'h03);
		c1(8'h30);
		`CHK(programError, 1'b0)
		st(ex);
		tprot <= 1'b0;
		c1(8'h06);
		a = 24'(xs());
		cmd({8'h20, a, 8'h0}, 4, 0);
		`CHK(lk, fsp_pkg::OPK_ERASE)
		`CHK(la, a)
		c1(8'h75);
		`CHK(nsus, 1)
		eng(1'b1);
		`CHK(eraseError, 1'b1)
		st(ex | 8'h03);
		c1(8'h30);
		st(ex);
		$display("end busy");
		ex[7] = 1'b1;
		vw(ex);
		wpN <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(regLock, 1'b1)
		vw(~ex);
		st(ex);
		for (int i = 1; i < 3; i++) begin
			{qpm, quad_io_mode} <= 2'(i);
			repeat (4) @(posedge clk);
			`CHK(regLock, 1'b0)
		end
		b = ex ^ 8'h5c;
		vw(b);
		ex = wv(b, ex);
		st(ex);
		{qpm, quad_io_mode} <= 2'b00;
		wpN <= 1'b1;
		b = ex & 8'h7f;
		vw(b);
		ex = wv(b, ex);
		st(ex);
		nv <= nv ^ 8'ha0;
		nvUpdate <= 1'b1;
		@(posedge clk) nvUpdate <= 1'b0;
		repeat (3) @(posedge clk);
		ex = {nv[7], ex[6], nv[5], ex[4:0]};
		`CHK(sr, ex)
		c1(8'h99);
		`CHK(nrst, 0)
		c1(8'h66);
		c1(8'h99);
		`CHK(nrst, 1)
		st(nv);
		$display("end lock");
		stop_test();
	end
endmodule : fsp_status_one_tb_top
bind fsp_status_one fsp_status_one_chk u_chk (.clk(clk), .rst_n(rst_n), .wpN(wpN), .nvUpdate(nvUpdate),
	.statusOneNonvolatile(statusOneNonvolatile), .opDone(opDone), .opFail(opFail), .opStart(opStart),
	.opKind(opKind), .suspendReq(suspendReq), .swResetPulse(swResetPulse), .statusOneVolatile(statusOneVolatile),
	.eraseError(eraseError), .programError(programError), .registerLock(registerLock));
